// ===== include/rlsa_params.svh
// Offsets, field positions, reset values and counts of the lane sync monitor
`ifndef RLSA_PARAMS_SVH
`define RLSA_PARAMS_SVH
`define RLSA_OFS_CTRL     8'h00
`define RLSA_OFS_LOCK     8'h04
`define RLSA_OFS_FAIL     8'h08
`define RLSA_OFS_LEN      8'h0C
`define RLSA_OFS_REPEAT   8'h10
`define RLSA_OFS_ALIGN    8'h14
`define RLSA_OFS_DESC_EVT 8'h18
`define RLSA_OFS_SYNC_EVT 8'h1C
`define RLSA_OFS_FRAM_EVT 8'h20
`define RLSA_MF_LEN_RST   16'h0800
`define RLSA_ALIGN_BIT    0
`define RLSA_ALIGN_ERR_BIT 1
`define RLSA_HDR_DATA     2'h1
`define RLSA_HDR_CTRL     2'h2
`define RLSA_LOCK_GOOD    8'h40
`define RLSA_HUNT_TRIES   8'h10
`define RLSA_BAD_WIN      8'h40
`define RLSA_BAD_MAX      8'h10
`define RLSA_SYNC_BAD_MAX 3'h4
`define RLSA_SCR_BAD_MAX  3'h3
`define RLSA_DESKEW_WIN   8'h10
`define RLSA_ALIGN_TRIES  4'h8
`endif

// ===== include/rlsa_pkg.sv
// Types shared by the lane sync monitor
package rlsa_pkg;
  typedef enum logic [2:0] {
    RLSA_HUNT   = 3'h1,
    RLSA_WLOCK  = 3'h2,
    RLSA_SYNCED = 3'h4
  } rlsa_lane_e;
  typedef enum logic [2:0] {
    RLSA_A_WAIT    = 3'h1,
    RLSA_A_MEAS    = 3'h2,
    RLSA_A_ALIGNED = 3'h4
  } rlsa_align_e;
endpackage

// ===== rtl/rlsa_lane.sv
// One receive lane: word boundary lock, meta frame checks and lane faults
`timescale 1ns/1ns
`include "rlsa_params.svh"
module rlsa_lane
  import rlsa_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [15:0] mf_len,
  input  wire logic        word_valid,
  input  wire logic [1:0]  hdr,
  input  wire logic        sync_word,
  input  wire logic        sync_ok,
  input  wire logic        scram_word,
  input  wire logic        scram_ok,
  output logic             lock,
  output logic             lock_fail,
  output logic             len_fault,
  output logic             repeat_fault,
  output logic             descram_fault,
  output logic             sync_fault,
  output logic             framing_fault,
  output logic             slip,
  output logic             sync_seen
);
  rlsa_lane_e  st_r, st_nxt;
  logic [7:0]  good_r, good_nxt, tries_r, tries_nxt, win_r, win_nxt, bad_r, bad_nxt;
  logic [17:0] mfc_r, mfc_nxt;
  logic [2:0]  sbad_r, sbad_nxt, cbad_r, cbad_nxt;
  logic        have_r, have_nxt;
  logic [2:0]  flg_r, flg_nxt;
  logic [4:0]  pls_r, pls_nxt;
  logic        hdr_ok;

  assign hdr_ok = (hdr == `RLSA_HDR_DATA) || (hdr == `RLSA_HDR_CTRL);

  always_comb
  begin
    st_nxt = st_r;
    good_nxt = good_r;
    tries_nxt = tries_r;
    win_nxt = win_r;
    bad_nxt = bad_r;
    mfc_nxt = mfc_r;
    sbad_nxt = sbad_r;
    cbad_nxt = cbad_r;
    have_nxt = have_r;
    flg_nxt = flg_r;
    pls_nxt = 5'h00;
    if (word_valid)
    begin
      unique case (st_r)
        RLSA_HUNT:
        begin
          if (!hdr_ok)
          begin
            good_nxt = 8'h00;
            pls_nxt[3] = 1'b1;
            tries_nxt = tries_r + 8'h01;
            if (tries_r == `RLSA_HUNT_TRIES - 8'h01)
            begin
              tries_nxt = 8'h00;
              flg_nxt = 3'h1;
            end
          end
          else if (good_r == `RLSA_LOCK_GOOD - 8'h01)
          begin
            // Fresh lock forgets every sticky lane fault
            st_nxt = RLSA_WLOCK;
            flg_nxt = 3'h0;
            {good_nxt, tries_nxt, win_nxt, bad_nxt} = 32'h0000_0000;
            {mfc_nxt, sbad_nxt, cbad_nxt, have_nxt} = 25'h0;
          end
          else
            good_nxt = good_r + 8'h01;
        end
        default:
        begin
          mfc_nxt = mfc_r + 18'h00001;
          win_nxt = win_r + 8'h01;
          if (win_r == `RLSA_BAD_WIN - 8'h01)
            {win_nxt, bad_nxt} = 16'h0000;
          if (!hdr_ok)
          begin
            pls_nxt[2] = 1'b1;
            bad_nxt = bad_r + 8'h01;
            if (bad_r == `RLSA_BAD_MAX - 8'h01)
            begin
              st_nxt = RLSA_HUNT;
              flg_nxt = 3'h1;
            end
          end
          else if (sync_word && sync_ok)
          begin
            mfc_nxt = 18'h00000;
            sbad_nxt = 3'h0;
            have_nxt = 1'b1;
            pls_nxt[4] = 1'b1;
            if (have_r && (mfc_r + 18'h00001 != {2'b00, mf_len}))
              flg_nxt = 3'h2;
            else if (have_r)
              st_nxt = RLSA_SYNCED;
          end
          else if (sync_word)
          begin
            mfc_nxt = 18'h00000;
            pls_nxt[1] = 1'b1;
            sbad_nxt = sbad_r + 3'h1;
            if (sbad_r == `RLSA_SYNC_BAD_MAX - 3'h1)
            begin
              st_nxt = RLSA_HUNT;
              flg_nxt = 3'h4;
            end
          end
          else if (scram_word && !scram_ok)
          begin
            pls_nxt[0] = 1'b1;
            cbad_nxt = cbad_r + 3'h1;
            if (cbad_r == `RLSA_SCR_BAD_MAX - 3'h1)
            begin
              st_nxt = RLSA_HUNT;
              flg_nxt = 3'h4;
            end
          end
          else if (!have_r && (mfc_r == {mf_len, 2'b00}))
          begin
            // No good sync word in four meta frames: the lock is false
            st_nxt = RLSA_HUNT;
            flg_nxt = 3'h1;
          end
          if (scram_word && scram_ok)
            cbad_nxt = 3'h0;
          if (st_nxt == RLSA_HUNT)
            {good_nxt, tries_nxt} = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      st_r <= RLSA_HUNT;
      {good_r, tries_r, win_r, bad_r} <= 32'h0000_0000;
      {mfc_r, sbad_r, cbad_r, have_r} <= 25'h0;
      flg_r <= 3'h0;
      pls_r <= 5'h00;
    end
    else
    begin
      st_r <= st_nxt;
      {good_r, tries_r, win_r, bad_r} <= {good_nxt, tries_nxt, win_nxt, bad_nxt};
      {mfc_r, sbad_r, cbad_r, have_r} <= {mfc_nxt, sbad_nxt, cbad_nxt, have_nxt};
      flg_r <= flg_nxt;
      pls_r <= pls_nxt;
    end
  end

  assign lock = (st_r == RLSA_SYNCED) && (flg_r == 3'h0);
  assign {repeat_fault, len_fault, lock_fail} = flg_r;
  assign {sync_seen, slip, framing_fault, sync_fault, descram_fault} = pls_r;

  a_lock_clean: assert property (@(posedge clock) disable iff (reset)
    lock |-> (st_r == RLSA_SYNCED) && !lock_fail && !len_fault && !repeat_fault)
    else $error("lane lock with a fault or without sync");
  a_fault_single: assert property (@(posedge clock) disable iff (reset)
    $onehot0(flg_r))
    else $error("lane faults not exclusive");
  a_lock_clears: assert property (@(posedge clock) disable iff (reset)
    $rose(st_r == RLSA_WLOCK) |-> flg_r == 3'h0)
    else $error("lane faults not cleared on word lock");
  a_sync_pulse: assert property (@(posedge clock) disable iff (reset)
    (word_valid && st_r != RLSA_HUNT && hdr_ok && sync_word && !sync_ok)
    |=> sync_fault ##1 (!sync_fault || $past(word_valid && sync_word)))
    else $error("invalid sync word not pulsed");
  a_repeat_sync: assert property (@(posedge clock) disable iff (reset)
    (word_valid && st_r != RLSA_HUNT && hdr_ok && sync_word && !sync_ok && sbad_r == 3'h3)
    |=> repeat_fault && st_r == RLSA_HUNT)
    else $error("fourth bad sync word missed");
  a_descram_lock: assert property (@(posedge clock) disable iff (reset)
    descram_fault |-> $past(st_r) != RLSA_HUNT && $past(scram_word && !scram_ok))
    else $error("descrambler fault outside lock");
endmodule // rlsa_lane

// ===== rtl/rlsa_top.sv
// Lane sync and alignment status monitor with an AHB-Lite register slave
`timescale 1ns/1ns
`include "rlsa_params.svh"
// Notes on behaviour
// - All status outputs change only on the rising clock edge.
// - Lane lock bit low while unlocked or any sticky fault flags that lane.
// - Lane lock high only after word lock and two good sync words at the configured spacing.
// - Lock failure raised when no word boundary is found from framing bits.
// - Lock failure raised on framing bit errors after word lock.
// - Lock failure raised when no good sync word ever follows word lock.
// - Sticky lane faults hold until new word lock or another lane fault.
// - Frame length fault when sync words arrive off the configured spacing.
// - Repeat fault after four invalid sync words in a row.
// - Repeat fault after three invalid scrambler state words in a row.
// - One-cycle descrambler fault per bad scrambler word, only when locked.
// - One-cycle sync word fault per invalid sync word, only when locked.
// - Aligned flag only when all lanes are deskewed and ready.
// - Alignment fault after several failed alignment attempts.
// - Alignment fault when the aligned flag drops.
// - One-cycle framing fault per illegal framing pattern after word lock.
// - Framing fault while aligned counts as a CRC24-class error.
// - A CRC24-class error marks every open receive packet as errored.
module rlsa_top
  import rlsa_pkg::*;
#(
  parameter int LANES = 4
)
(
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic [LANES-1:0]  word_valid,
  input  wire logic [2*LANES-1:0] word_hdr,
  input  wire logic [LANES-1:0]  sync_word,
  input  wire logic [LANES-1:0]  sync_ok,
  input  wire logic [LANES-1:0]  scram_word,
  input  wire logic [LANES-1:0]  scram_ok,
  input  wire logic              crc24_err,
  output logic [LANES-1:0]       lane_lock,
  output logic [LANES-1:0]       lane_lock_fail,
  output logic [LANES-1:0]       lane_frame_len_fault,
  output logic [LANES-1:0]       lane_repeat_fault,
  output logic [LANES-1:0]       lane_descram_fault,
  output logic [LANES-1:0]       lane_sync_word_fault,
  output logic [LANES-1:0]       lane_framing_fault,
  output logic [LANES-1:0]       lane_slip,
  output logic                   rx_aligned,
  output logic                   rx_align_fault,
  output logic                   open_pkt_err
);
  logic [15:0]      mf_len_r, mf_len_nxt;
  logic [LANES-1:0] sync_seen;
  logic             all_lock;

  // Lanes
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1)
    begin : g_lane
      rlsa_lane u_lane (
        .clock         (clock),
        .reset         (reset),
        .mf_len        (mf_len_r),
        .word_valid    (word_valid[g]),
        .hdr           (word_hdr[2*g+1:2*g]),
        .sync_word     (sync_word[g]),
        .sync_ok       (sync_ok[g]),
        .scram_word    (scram_word[g]),
        .scram_ok      (scram_ok[g]),
        .lock          (lane_lock[g]),
        .lock_fail     (lane_lock_fail[g]),
        .len_fault     (lane_frame_len_fault[g]),
        .repeat_fault  (lane_repeat_fault[g]),
        .descram_fault (lane_descram_fault[g]),
        .sync_fault    (lane_sync_word_fault[g]),
        .framing_fault (lane_framing_fault[g]),
        .slip          (lane_slip[g]),
        .sync_seen     (sync_seen[g])
      );
    end
  endgenerate

  assign all_lock = &lane_lock;

  // Alignment: all lanes must see their sync word within one deskew window
  rlsa_align_e      ast_r, ast_nxt;
  logic [LANES-1:0] acc_r, acc_nxt;
  logic [7:0]       wcnt_r, wcnt_nxt;
  logic [3:0]       try_r, try_nxt;
  logic             aerr_r, aerr_nxt;

  always_comb
  begin
    ast_nxt = ast_r;
    acc_nxt = acc_r | sync_seen;
    wcnt_nxt = wcnt_r + 8'h01;
    try_nxt = try_r;
    aerr_nxt = aerr_r;
    unique case (ast_r)
      RLSA_A_WAIT:
      begin
        acc_nxt = sync_seen;
        wcnt_nxt = 8'h00;
        if (all_lock && (|sync_seen))
          ast_nxt = RLSA_A_MEAS;
      end
      RLSA_A_MEAS:
      begin
        if (!all_lock)
          ast_nxt = RLSA_A_WAIT;
        else if (&acc_nxt)
        begin
          ast_nxt = RLSA_A_ALIGNED;
          try_nxt = 4'h0;
          aerr_nxt = 1'b0;
        end
        else if (wcnt_r == `RLSA_DESKEW_WIN - 8'h01)
        begin
          ast_nxt = RLSA_A_WAIT;
          try_nxt = try_r + 4'h1;
          if (try_r == `RLSA_ALIGN_TRIES - 4'h1)
          begin
            try_nxt = 4'h0;
            aerr_nxt = 1'b1;
          end
        end
      end
      RLSA_A_ALIGNED:
      begin
        if (!all_lock)
        begin
          ast_nxt = RLSA_A_WAIT;
          aerr_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ast_r <= RLSA_A_WAIT;
      acc_r <= '0;
      wcnt_r <= 8'h00;
      try_r <= 4'h0;
      aerr_r <= 1'b0;
    end
    else
    begin
      ast_r <= ast_nxt;
      acc_r <= acc_nxt;
      wcnt_r <= wcnt_nxt;
      try_r <= try_nxt;
      aerr_r <= aerr_nxt;
    end
  end

  assign rx_aligned = (ast_r == RLSA_A_ALIGNED);
  assign rx_align_fault = aerr_r;

  // Packet error marking; framing slips before alignment carry no packets
  logic pkt_err_r, pkt_err_nxt;
  assign pkt_err_nxt = crc24_err || (rx_aligned && (|lane_framing_fault));
  always_ff @(posedge clock)
  begin
    if (reset)
      pkt_err_r <= 1'b0;
    else
      pkt_err_r <= pkt_err_nxt;
  end
  assign open_pkt_err = pkt_err_r;

  // AHB-Lite slave, zero wait states, word access only
  logic             wr_r, wr_nxt;
  logic [7:0]       wad_r, wad_nxt;
  logic [31:0]      rd_r, rd_nxt;
  logic [LANES-1:0] desc_evt_r, desc_evt_nxt;
  logic [LANES-1:0] sync_evt_r, sync_evt_nxt;
  logic [LANES-1:0] fram_evt_r, fram_evt_nxt;
  logic             req;

  // Sub-word accesses are ignored: a write is dropped and a read returns zero
  assign req = hsel && hready && htrans[1] && (hsize == 3'h2);

  always_comb
  begin
    wr_nxt = req && hwrite;
    wad_nxt = haddr[7:0];
    mf_len_nxt = mf_len_r;
    if (wr_r && (wad_r == `RLSA_OFS_CTRL))
      mf_len_nxt = hwdata[15:0];
    // Write-one-to-clear; a new event in the same cycle wins
    desc_evt_nxt = desc_evt_r;
    sync_evt_nxt = sync_evt_r;
    fram_evt_nxt = fram_evt_r;
    if (wr_r && (wad_r == `RLSA_OFS_DESC_EVT))
      desc_evt_nxt = desc_evt_r & ~hwdata[LANES-1:0];
    if (wr_r && (wad_r == `RLSA_OFS_SYNC_EVT))
      sync_evt_nxt = sync_evt_r & ~hwdata[LANES-1:0];
    if (wr_r && (wad_r == `RLSA_OFS_FRAM_EVT))
      fram_evt_nxt = fram_evt_r & ~hwdata[LANES-1:0];
    desc_evt_nxt = desc_evt_nxt | lane_descram_fault;
    sync_evt_nxt = sync_evt_nxt | lane_sync_word_fault;
    fram_evt_nxt = fram_evt_nxt | lane_framing_fault;
    rd_nxt = 32'h0000_0000;
    if (req && !hwrite)
    begin
      unique case (haddr[7:0])
        `RLSA_OFS_CTRL:     rd_nxt[15:0] = mf_len_nxt;
        `RLSA_OFS_LOCK:     rd_nxt[LANES-1:0] = lane_lock;
        `RLSA_OFS_FAIL:     rd_nxt[LANES-1:0] = lane_lock_fail;
        `RLSA_OFS_LEN:      rd_nxt[LANES-1:0] = lane_frame_len_fault;
        `RLSA_OFS_REPEAT:   rd_nxt[LANES-1:0] = lane_repeat_fault;
        `RLSA_OFS_ALIGN:
        begin
          rd_nxt[`RLSA_ALIGN_BIT] = rx_aligned;
          rd_nxt[`RLSA_ALIGN_ERR_BIT] = rx_align_fault;
        end
        `RLSA_OFS_DESC_EVT: rd_nxt[LANES-1:0] = desc_evt_nxt;
        `RLSA_OFS_SYNC_EVT: rd_nxt[LANES-1:0] = sync_evt_nxt;
        `RLSA_OFS_FRAM_EVT: rd_nxt[LANES-1:0] = fram_evt_nxt;
        default:            rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wr_r <= 1'b0;
      wad_r <= 8'h00;
      rd_r <= 32'h0000_0000;
      mf_len_r <= `RLSA_MF_LEN_RST;
      desc_evt_r <= '0;
      sync_evt_r <= '0;
      fram_evt_r <= '0;
    end
    else
    begin
      wr_r <= wr_nxt;
      wad_r <= wad_nxt;
      rd_r <= rd_nxt;
      mf_len_r <= mf_len_nxt;
      desc_evt_r <= desc_evt_nxt;
      sync_evt_r <= sync_evt_nxt;
      fram_evt_r <= fram_evt_nxt;
    end
  end

  // Read data is registered one cycle after the address, so no wait state is needed
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_r;

  a_aligned_rise: assert property (@(posedge clock) disable iff (reset)
    $rose(rx_aligned) |-> $past(all_lock) && $past(ast_r == RLSA_A_MEAS))
    else $error("aligned without all lanes locked");
  a_align_lost: assert property (@(posedge clock) disable iff (reset)
    (rx_aligned && !all_lock) |=> !rx_aligned && rx_align_fault)
    else $error("alignment loss not flagged");
  a_align_tries: assert property (@(posedge clock) disable iff (reset)
    ($rose(rx_align_fault) && !$past(rx_aligned))
    |-> $past(try_r) == `RLSA_ALIGN_TRIES - 4'h1 && $past(wcnt_r) == `RLSA_DESKEW_WIN - 8'h01)
    else $error("alignment fault without exhausted attempts");
  a_framing_crc: assert property (@(posedge clock) disable iff (reset)
    (rx_aligned && (|lane_framing_fault)) |=> open_pkt_err)
    else $error("framing fault while aligned not marked");
  a_pkt_err_src: assert property (@(posedge clock) disable iff (reset)
    open_pkt_err |-> $past(crc24_err) || $past(rx_aligned && (|lane_framing_fault)))
    else $error("packet error without a cause");
  a_reset_clear: assert property (@(posedge clock) disable iff (reset)
    $fell(reset) |-> (lane_lock == '0) && !rx_aligned && !rx_align_fault && !open_pkt_err
      && (lane_lock_fail == '0) && (lane_repeat_fault == '0) && (hrdata == 32'h0000_0000))
    else $error("status not clear after reset");
  a_len_write: assert property (@(posedge clock) disable iff (reset)
    (wr_r && wad_r == `RLSA_OFS_CTRL) |=> mf_len_r == $past(hwdata[15:0]))
    else $error("meta frame length write lost");
  a_evt_sticky: assert property (@(posedge clock) disable iff (reset)
    (|lane_descram_fault)
    |=> ((desc_evt_r & $past(lane_descram_fault)) == $past(lane_descram_fault)))
    else $error("descrambler event not captured");
endmodule // rlsa_top

// ===== tb/rlsa_tx_model.sv
// Far-end lane transmitter model feeding every receive lane
`timescale 1ns/1ns
`include "rlsa_params.svh"
module rlsa_tx_model
#(
  parameter int LANES = 4
)
(
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic [15:0]        mf_len,
  input  wire logic [2:0]         mode,
  output logic [LANES-1:0]        word_valid,
  output logic [2*LANES-1:0]      word_hdr,
  output logic [LANES-1:0]        sync_word,
  output logic [LANES-1:0]        sync_ok,
  output logic [LANES-1:0]        scram_word,
  output logic [LANES-1:0]        scram_ok
);
  // Only lane 0 carries injected faults; mode 4 stretches its frame by one word
  logic [15:0] pos_r;
  logic [15:0] pos0_r;
  logic [15:0] len0;
  logic [15:0] pl [LANES];
  assign len0 = (mode == 3'h4) ? mf_len + 16'h0001 : mf_len;
  always_comb
  begin
    for (int n = 0; n < LANES; n++)
      pl[n] = (n == 0) ? pos0_r : pos_r;
  end
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pos_r <= 16'h0000;
      pos0_r <= 16'h0000;
      word_valid <= '0;
      word_hdr <= '0;
      sync_word <= '0;
      sync_ok <= '0;
      scram_word <= '0;
      scram_ok <= '0;
    end
    else
    begin
      pos_r <= (pos_r >= mf_len - 16'h0001) ? 16'h0000 : pos_r + 16'h0001;
      pos0_r <= (pos0_r >= len0 - 16'h0001) ? 16'h0000 : pos0_r + 16'h0001;
      word_valid <= '1;
      for (int n = 0; n < LANES; n++)
      begin
        sync_word[n] <= (pl[n] == 16'h0000) && !(n == 0 && mode == 3'h5);
        sync_ok[n] <= (pl[n] == 16'h0000) && !(n == 0 && mode == 3'h2);
        scram_word[n] <= (pl[n] == 16'h0001);
        scram_ok[n] <= (pl[n] == 16'h0001) && !(n == 0 && mode == 3'h3);
        word_hdr[2*n+:2] <= (n == 0 && mode == 3'h1) ? 2'h3 :
                            (pl[n] < 16'h0002) ? `RLSA_HDR_CTRL : `RLSA_HDR_DATA;
      end
    end
  end
endmodule // rlsa_tx_model

// ===== tb/rlsa_top_tb_top.sv
// Self-checking bench for the lane sync and alignment monitor
`timescale 1ns/1ns
`include "rlsa_params.svh"
module rlsa_top_tb_top;
  localparam int LANES = 4;
  logic              clock;
  logic              reset;
  logic              hsel;
  logic [31:0]       haddr;
  logic [1:0]        htrans;
  logic              hwrite;
  logic [2:0]        hsize;
  logic [31:0]       hwdata;
  logic              hreadyout;
  logic              hresp;
  logic [31:0]       hrdata;
  logic              crc24_err;
  logic [2:0]        mode;
  logic [15:0]       mf_len;
  logic [LANES-1:0]  wv, sw, so, cw, co, lk, lf, ln, rp, de, sf, ff, sl;
  logic [2*LANES-1:0] hd;
  logic              rx_aligned;
  logic              rx_align_fault;
  logic              open_pkt_err;
  logic [9:0]        mon;
  int                err_total;
  int                comparisons;
  assign mon = {rx_align_fault, &lk & rx_aligned, sl[0], open_pkt_err, ff[0], de[0], sf[0],
                rp[0], ln[0], lf[0]};
  rlsa_top #(.LANES(LANES)) i_rlsa_top (.clock(clock), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .word_valid(wv), .word_hdr(hd), .sync_word(sw), .sync_ok(so), .scram_word(cw),
    .scram_ok(co), .crc24_err(crc24_err), .lane_lock(lk), .lane_lock_fail(lf),
    .lane_frame_len_fault(ln), .lane_repeat_fault(rp), .lane_descram_fault(de),
    .lane_sync_word_fault(sf), .lane_framing_fault(ff), .lane_slip(sl),
    .rx_aligned(rx_aligned), .rx_align_fault(rx_align_fault), .open_pkt_err(open_pkt_err));
  rlsa_tx_model #(.LANES(LANES)) i_rlsa_tx_model (.clock(clock), .reset(reset),
    .mf_len(mf_len), .mode(mode), .word_valid(wv), .word_hdr(hd), .sync_word(sw),
    .sync_ok(so), .scram_word(cw), .scram_ok(co));
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Waits are bounded so a missing event shows up as a mismatch, not a hang
  task automatic wait_bit(input int b, input int lim, input string name);
    for (int i = 0; i < lim; i++)
    begin
      @(posedge clock);
      #1;
      if (mon[b] === 1'b1)
        break;
    end
    check(name, mon[b], 1'b1);
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    check(name, v, exp);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] v;
    ahb(1'b1, a, d, v);
  endtask
  task automatic set_mode(input logic [2:0] m);
    @(posedge clock);
    mode <= m;
  endtask
  task automatic heal;
    set_mode(3'h0);
    wait_bit(8, 900, "relock");
    rd_chk("fail reg", `RLSA_OFS_FAIL, 32'h0);
    rd_chk("repeat reg", `RLSA_OFS_REPEAT, 32'h0);
    rd_chk("len reg", `RLSA_OFS_LEN, 32'h0);
    rd_chk("align reg", `RLSA_OFS_ALIGN, 32'h1);
  endtask
  task automatic t_reset;
    #1;
    check("status", {lk, lf, ln, rp, de, sf, ff, rx_aligned, rx_align_fault}, 32'h0);
    check("hreadyout", hreadyout, 1'b1);
    check("hresp", hresp, 1'b0);
    rd_chk("ctrl rst", `RLSA_OFS_CTRL, {16'h0, `RLSA_MF_LEN_RST});
    wr(`RLSA_OFS_CTRL, {16'h0, mf_len});
    rd_chk("ctrl", `RLSA_OFS_CTRL, {16'h0, mf_len});
    wr(`RLSA_OFS_LOCK, 32'hF);
    rd_chk("lock ro", `RLSA_OFS_LOCK, 32'h0);
    rd_chk("unmapped", 32'h40, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_lock;
    wait_bit(8, 900, "aligned");
    rd_chk("lock reg", `RLSA_OFS_LOCK, 32'hF);
    $display("test lock done");
  endtask
  task automatic t_sync;
    set_mode(3'h2);
    wait_bit(3, 40, "sync pulse");
    wait_bit(2, 60, "repeat sync");
    check("lane lock", lk[0], 1'b0);
    wait_bit(9, 4, "align fault");
    check("aligned", rx_aligned, 1'b0);
    heal();
    rd_chk("sync evt", `RLSA_OFS_SYNC_EVT, 32'h1);
    wr(`RLSA_OFS_SYNC_EVT, 32'h1);
    rd_chk("sync evt clr", `RLSA_OFS_SYNC_EVT, 32'h0);
    $display("test sync done");
  endtask
  task automatic t_scram;
    set_mode(3'h3);
    wait_bit(4, 40, "descram pulse");
    wait_bit(2, 60, "repeat scram");
    heal();
    rd_chk("desc evt", `RLSA_OFS_DESC_EVT, 32'h1);
    $display("test scram done");
  endtask
  task automatic t_nosync;
    // A lane that once saw a good sync word never reports this: force a fresh word lock
    set_mode(3'h1);
    wait_bit(0, 200, "drop lock");
    set_mode(3'h5);
    repeat (80) @(posedge clock);
    #1;
    check("relock clears fail", lf[0], 1'b0);
    wait_bit(0, 60, "no sync fail");
    heal();
    $display("test nosync done");
  endtask
  task automatic t_hdr;
    set_mode(3'h1);
    wait_bit(5, 20, "framing pulse");
    @(posedge clock);
    #1;
    check("open pkt err", open_pkt_err, 1'b1);
    wait_bit(0, 200, "hdr fail");
    wait_bit(7, 40, "slip");
    repeat (40) @(posedge clock);
    #1;
    check("fail held", lf[0], 1'b1);
    heal();
    rd_chk("fram evt", `RLSA_OFS_FRAM_EVT, 32'h1);
    $display("test hdr done");
  endtask
  task automatic t_len;
    set_mode(3'h4);
    wait_bit(1, 60, "len fault");
    check("len lock", lk[0], 1'b0);
    set_mode(3'h1);
    wait_bit(0, 200, "fail over len");
    check("len gone", ln[0], 1'b0);
    heal();
    $display("test len done");
  endtask
  task automatic t_crc;
    @(posedge clock);
    crc24_err <= 1'b1;
    @(posedge clock);
    crc24_err <= 1'b0;
    #1;
    check("crc open err", open_pkt_err, 1'b1);
    $display("test crc done");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #400000;
    err_total++;
    results();
  end
  initial
  begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    crc24_err = 1'b0;
    mode = 3'h0;
    mf_len = 16'h0008;
    err_total = 0;
    comparisons = 0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset();
    t_lock();
    t_sync();
    t_scram();
    t_nosync();
    t_hdr();
    t_len();
    t_crc();
    results();
  end
endmodule // rlsa_top_tb_top
